// *** include/ssen_defs.vh ***
`ifndef SSEN_DEFS_VH
`define SSEN_DEFS_VH
// Register indices; byte address is four times the index
`define SSEN_IDX_PWR      8'h80
`define SSEN_IDX_IRQ_CFG  8'hb2
`define SSEN_IDX_GAIN_LIM 8'hb3
`define SSEN_IDX_THR_CH   8'hb5
`define SSEN_IDX_PERSIST  8'hbd
`define SSEN_IDX_PIN_CTL  8'hbe
`define SSEN_IDX_STEP_LO  8'hca
`define SSEN_IDX_STEP_HI  8'hcb
`define SSEN_IDX_AGC_CEIL 8'hcf
`define SSEN_IDX_AZ_CFG   8'hd6
`define SSEN_IDX_FD_CFG   8'hd7
`define SSEN_IDX_FD_T_LO  8'hd8
`define SSEN_IDX_FD_T_HI  8'hda
`define SSEN_IDX_FD_RES   8'hdb
`define SSEN_IDX_EVT_STAT 8'he0
`define SSEN_IDX_EVT_MASK 8'he1
`define SSEN_IDX_WAIT_LEN 8'he2
`define SSEN_IDX_IRQ_EN   8'hf9
`define SSEN_IDX_ACTIONS  8'hfa
`define SSEN_IDX_BUF_MAP  8'hfc
`define SSEN_IDX_BUF_LVL  8'hfd
`define SSEN_IDX_BUF_LO   8'hfe
`define SSEN_IDX_BUF_HI   8'hff
// Power and function register bits
`define SSEN_PWR_ON       0
`define SSEN_PWR_RUN      1
`define SSEN_PWR_WAIT     3
`define SSEN_PWR_MUX      4
`define SSEN_PWR_FLICK    6
`define SSEN_PWR_MASK     8'h5b
// Event status bits
`define SSEN_EVT_MUX      0
`define SSEN_EVT_FLICK    1
`define SSEN_EVT_CFG      2
`define SSEN_EVT_MEAS     3
`define SSEN_EVT_N        4
// Interrupt enable and source bits
`define SSEN_IEN_SYS      0
`define SSEN_SRC_FD       6
`define SSEN_SRC_MUX      4
// Reset values and write masks
`define SSEN_RST_BYTE     8'h00
`define SSEN_RST_PIN_CTL  8'h02
`define SSEN_PIN_CTL_MASK 8'h0e
`define SSEN_ACT_MASK     8'h07
// Timing: one integration step
`define SSEN_CLK_NS       10
`define SSEN_STEP_NS      1000
`define SSEN_STEP_CYC     (`SSEN_STEP_NS / `SSEN_CLK_NS)
`endif

// *** hdl/ssen_regs.v ***
// Contract
// - Config writes during spectral run may corrupt results; device flags them.
// - Bit 0 starts the oscillator tick; clearing it stops everything; resets 0.
// - Writing 1 to bit 4 launches a mux command; bit self-clears when done.
// - Bit 6 switches flicker detection on or off; resets 0.
// - Bit 3 inserts a wait interval between consecutive measurements.
// - Bit 1 gates spectral measurement; polarity is a parameter.
// - Self-clearing bits return to zero; read-only bits ignore writes.
// - Auto-gain ceiling: flicker gain bits 7:4, spectral gain bits 3:0.
// - System interrupt on flicker change or mux done when enabled.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "ssen_defs.vh"
module ssen_regs #(
   parameter RUN_WHEN_ONE = 1
) (
   input  wire        CLK_SYS_I,
   input  wire        RSTN_I,
   input  wire [9:0]  AVS_ADDRESS_I,
   input  wire        AVS_READ_I,
   input  wire        AVS_WRITE_I,
   input  wire [31:0] AVS_WRITEDATA_I,
   input  wire [3:0]  AVS_BYTEENABLE_I,
   output reg  [31:0] AVS_READDATA_O,
   output wire        AVS_WAITREQUEST_O,
   input  wire        MUX_DONE_I,
   input  wire [7:0]  FLICKER_STATUS_I,
   input  wire        PIN_IN_I,
   input  wire [7:0]  BUF_LEVEL_I,
   input  wire [15:0] BUF_DATA_I,
   output wire        OSC_EN_O,
   output wire        MEAS_RUN_O,
   output wire        FLICKER_EN_O,
   output reg         MUX_START_O,
   output reg         INTEG_ACTIVE_O,
   output reg         MEAS_DONE_O,
   output reg         BUF_POP_O,
   output reg  [2:0]  ACTION_O,
   output wire [15:0] INTEG_STEP_O,
   output wire [3:0]  FLICKER_GAIN_CEIL_O,
   output wire [3:0]  SPECTRAL_GAIN_CEIL_O,
   output wire [7:0]  PIN_CTL_O,
   output wire        IRQ_O
);

   // Sequencer states and the step length in clock cycles
   localparam ST_IDLE  = 2'd0;
   localparam ST_INTEG = 2'd1;
   localparam ST_WAIT  = 2'd2;
   localparam integer STEP_CYC_W = `SSEN_STEP_CYC;
   localparam [15:0]  STEP_CYC   = STEP_CYC_W[15:0];

   // Register storage and sequencer state
   reg  [7:0]  pwr_q;
   reg  [7:0]  irq_cfg_q;
   reg  [7:0]  gain_lim_q;
   reg  [7:0]  thr_ch_q;
   reg  [7:0]  persist_q;
   reg  [7:0]  pin_ctl_q;
   reg  [7:0]  step_lo_q;
   reg  [7:0]  step_hi_q;
   reg  [7:0]  agc_ceil_q;
   reg  [7:0]  az_cfg_q;
   reg  [7:0]  fd_cfg_q;
   reg  [7:0]  fd_t_lo_q;
   reg  [7:0]  fd_t_hi_q;
   reg  [7:0]  irq_en_q;
   reg  [7:0]  buf_map_q;
   reg  [7:0]  wait_len_q;
   reg  [7:0]  evt_mask_q;
   reg  [3:0]  evt_stat_q;
   reg         ack_q;
   reg  [7:0]  rd_d;
   reg  [7:0]  fd_prev_q;
   reg  [15:0] tick_cnt_q;
   reg  [15:0] step_cnt_q;
   reg  [1:0]  state_q;
   reg         cfg_hit;

   // Bus decode and shared terms
   wire [7:0]  idx   = AVS_ADDRESS_I[9:2];
   wire        req   = AVS_READ_I | AVS_WRITE_I;
   wire        wr    = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0] & (AVS_ADDRESS_I[1:0] == 2'b00);
   wire        rd    = AVS_READ_I & ack_q;
   wire [7:0]  wd    = AVS_WRITEDATA_I[7:0];
   wire        power_on_bit   = pwr_q[`SSEN_PWR_ON];
   wire        run_b = pwr_q[`SSEN_PWR_RUN];
   wire        tick  = power_on_bit & (tick_cnt_q == STEP_CYC - 16'd1);
   wire        fd_chg = power_on_bit & (FLICKER_STATUS_I != fd_prev_q);
   wire [3:0]  evt_set;
   wire [3:0]  evt_clr;

   // Bus answer one cycle after the request is seen
   // Every access costs exactly one wait cycle, reads and writes alike
   // Read data are latched in the wait cycle, so they stand when taken
   // Writes land at the edge where waitrequest is low
   assign AVS_WAITREQUEST_O = req & ~ack_q;

   // Oscillator and function gates
   // Power-on gates every function, so a cleared power bit stops all
   // Enable bits written with power off stay inert until power-on
   assign OSC_EN_O     = power_on_bit;
   assign MEAS_RUN_O   = power_on_bit & (RUN_WHEN_ONE != 0 ? run_b : ~run_b);
   assign FLICKER_EN_O = power_on_bit & pwr_q[`SSEN_PWR_FLICK];
   assign INTEG_STEP_O = {step_hi_q, step_lo_q};
   assign FLICKER_GAIN_CEIL_O  = agc_ceil_q[7:4];
   assign SPECTRAL_GAIN_CEIL_O = agc_ceil_q[3:0];
   assign PIN_CTL_O = pin_ctl_q;

   // Config write while measuring flags possibly bad results
   // Only bytes that shape a running measurement count here
   // Interrupt, buffer and flicker bytes are left out on purpose
   always @* begin
      cfg_hit = 1'b0;
      case (idx)
         `SSEN_IDX_GAIN_LIM,
         `SSEN_IDX_THR_CH,
         `SSEN_IDX_PERSIST,
         `SSEN_IDX_STEP_LO,
         `SSEN_IDX_STEP_HI,
         `SSEN_IDX_AGC_CEIL,
         `SSEN_IDX_AZ_CFG,
         `SSEN_IDX_WAIT_LEN: cfg_hit = 1'b1;
         default: cfg_hit = 1'b0;
      endcase
   end

   // Event sources
   // Mux done counts only while a launch is pending
   // Measurement done comes from the sequencer pulse
   assign evt_set[`SSEN_EVT_MUX]   = pwr_q[`SSEN_PWR_MUX] & MUX_DONE_I;
   assign evt_set[`SSEN_EVT_FLICK] = fd_chg;
   assign evt_set[`SSEN_EVT_CFG]   = wr & cfg_hit & MEAS_RUN_O;
   assign evt_set[`SSEN_EVT_MEAS]  = MEAS_DONE_O;
   assign evt_clr = (wr && idx == `SSEN_IDX_EVT_STAT) ? wd[3:0] : 4'h0;

   // Sticky status, set wins over write-one-clear
   // A clear meeting a new event loses, so no event is missed
   // One flop per status bit
   genvar g;
   generate
      for (g = 0; g < `SSEN_EVT_N; g = g + 1) begin : g_evt
         always @(posedge CLK_SYS_I or negedge RSTN_I) begin
            if (!RSTN_I) begin
               evt_stat_q[g] <= 1'b0;
            end else if (evt_set[g]) begin
               evt_stat_q[g] <= 1'b1;
            end else if (evt_clr[g]) begin
               evt_stat_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // System events also need the system enable and their source enable
   // Measurement and config events need only their mask bit
   // The output is a level and drops once the status is cleared
   assign IRQ_O = |(evt_stat_q & evt_mask_q[3:0] & {1'b1, 1'b1,
                  irq_en_q[`SSEN_IEN_SYS] & irq_cfg_q[`SSEN_SRC_FD],
                  irq_en_q[`SSEN_IEN_SYS] & irq_cfg_q[`SSEN_SRC_MUX]});

   // Bus acknowledge and flicker status history
   // Acknowledge alternates, so a request held past its answer is taken again every second cycle
   // A flicker change while powered down shows at power-on
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ack_q     <= 1'b0;
         fd_prev_q <= 8'h00;
      end else begin
         ack_q     <= req & ~ack_q;
         fd_prev_q <= power_on_bit ? FLICKER_STATUS_I : fd_prev_q;
      end
   end

   // Power and function register
   // Reserved bits are masked on write and read back zero
   // Launch bit stays set until the mux reports done
   // A launch while one is pending gives no new start pulse
   // Dropping power also drops a pending launch
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pwr_q       <= `SSEN_RST_BYTE;
         MUX_START_O <= 1'b0;
      end else begin
         MUX_START_O <= 1'b0;
         if (wr && idx == `SSEN_IDX_PWR) begin
            pwr_q <= wd & `SSEN_PWR_MASK;
            if (wd[`SSEN_PWR_ON] == 1'b0) begin
               pwr_q[`SSEN_PWR_MUX] <= 1'b0;
            end else if (wd[`SSEN_PWR_MUX]) begin
               pwr_q[`SSEN_PWR_MUX] <= 1'b1;
               MUX_START_O <= ~pwr_q[`SSEN_PWR_MUX];
            end else begin
               pwr_q[`SSEN_PWR_MUX] <= pwr_q[`SSEN_PWR_MUX] & ~MUX_DONE_I;
            end
         end else if (MUX_DONE_I) begin
            pwr_q[`SSEN_PWR_MUX] <= 1'b0;
         end
      end
   end

   // Plain read-write configuration bytes
   // Undocumented resets are zero, pin control excepted
   // Input bit of pin control is never stored
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         irq_cfg_q  <= `SSEN_RST_BYTE;
         gain_lim_q <= `SSEN_RST_BYTE;
         thr_ch_q   <= `SSEN_RST_BYTE;
         persist_q  <= `SSEN_RST_BYTE;
         pin_ctl_q  <= `SSEN_RST_PIN_CTL;
         step_lo_q  <= `SSEN_RST_BYTE;
         step_hi_q  <= `SSEN_RST_BYTE;
         agc_ceil_q <= `SSEN_RST_BYTE;
         az_cfg_q   <= `SSEN_RST_BYTE;
         fd_cfg_q   <= `SSEN_RST_BYTE;
         fd_t_lo_q  <= `SSEN_RST_BYTE;
         fd_t_hi_q  <= `SSEN_RST_BYTE;
         irq_en_q   <= `SSEN_RST_BYTE;
         buf_map_q  <= `SSEN_RST_BYTE;
         wait_len_q <= `SSEN_RST_BYTE;
         evt_mask_q <= `SSEN_RST_BYTE;
      end else if (wr) begin
         case (idx)
            `SSEN_IDX_IRQ_CFG:  irq_cfg_q  <= wd;
            `SSEN_IDX_GAIN_LIM: gain_lim_q <= wd;
            `SSEN_IDX_THR_CH:   thr_ch_q   <= wd;
            `SSEN_IDX_PERSIST:  persist_q  <= wd;
            `SSEN_IDX_PIN_CTL:  pin_ctl_q  <= wd & `SSEN_PIN_CTL_MASK;
            `SSEN_IDX_STEP_LO:  step_lo_q  <= wd;
            `SSEN_IDX_STEP_HI:  step_hi_q  <= wd;
            `SSEN_IDX_AGC_CEIL: agc_ceil_q <= wd;
            `SSEN_IDX_AZ_CFG:   az_cfg_q   <= wd;
            `SSEN_IDX_FD_CFG:   fd_cfg_q   <= wd;
            `SSEN_IDX_FD_T_LO:  fd_t_lo_q  <= wd;
            `SSEN_IDX_FD_T_HI:  fd_t_hi_q  <= wd;
            `SSEN_IDX_IRQ_EN:   irq_en_q   <= wd;
            `SSEN_IDX_BUF_MAP:  buf_map_q  <= wd;
            `SSEN_IDX_WAIT_LEN: wait_len_q <= wd;
            `SSEN_IDX_EVT_MASK: evt_mask_q <= wd;
            default: ;
         endcase
      end
   end

   // Action strobes and buffer pop, one cycle each
   // Action bits are never stored and read back zero
   // Pop follows the answered read of the high data byte
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ACTION_O  <= 3'b000;
         BUF_POP_O <= 1'b0;
      end else begin
         ACTION_O  <= (wr && idx == `SSEN_IDX_ACTIONS) ? wd[2:0] : 3'b000;
         BUF_POP_O <= rd & (idx == `SSEN_IDX_BUF_HI);
      end
   end

   // Read multiplexer; write-only and unmapped read zero
   // Pin input shows only while its input enable is set
   always @* begin
      rd_d = 8'h00;
      case (idx)
         `SSEN_IDX_PWR:      rd_d = pwr_q & `SSEN_PWR_MASK;
         `SSEN_IDX_IRQ_CFG:  rd_d = irq_cfg_q;
         `SSEN_IDX_GAIN_LIM: rd_d = gain_lim_q;
         `SSEN_IDX_THR_CH:   rd_d = thr_ch_q;
         `SSEN_IDX_PERSIST:  rd_d = persist_q;
         `SSEN_IDX_PIN_CTL:  rd_d = {pin_ctl_q[7:1], PIN_IN_I & pin_ctl_q[2]};
         `SSEN_IDX_STEP_LO:  rd_d = step_lo_q;
         `SSEN_IDX_STEP_HI:  rd_d = step_hi_q;
         `SSEN_IDX_AGC_CEIL: rd_d = agc_ceil_q;
         `SSEN_IDX_AZ_CFG:   rd_d = az_cfg_q;
         `SSEN_IDX_FD_CFG:   rd_d = fd_cfg_q;
         `SSEN_IDX_FD_T_LO:  rd_d = fd_t_lo_q;
         `SSEN_IDX_FD_T_HI:  rd_d = fd_t_hi_q;
         `SSEN_IDX_FD_RES:   rd_d = FLICKER_STATUS_I;
         `SSEN_IDX_EVT_STAT: rd_d = {4'h0, evt_stat_q};
         `SSEN_IDX_EVT_MASK: rd_d = evt_mask_q;
         `SSEN_IDX_WAIT_LEN: rd_d = wait_len_q;
         `SSEN_IDX_IRQ_EN:   rd_d = irq_en_q;
         `SSEN_IDX_BUF_MAP:  rd_d = buf_map_q;
         `SSEN_IDX_BUF_LVL:  rd_d = BUF_LEVEL_I;
         `SSEN_IDX_BUF_LO:   rd_d = BUF_DATA_I[7:0];
         `SSEN_IDX_BUF_HI:   rd_d = BUF_DATA_I[15:8];
         default:            rd_d = 8'h00;
      endcase
   end

   // Read data register
   // Latched in the wait cycle and held until the next read
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         AVS_READDATA_O <= 32'h0000_0000;
      end else if (AVS_READ_I & ~ack_q) begin
         AVS_READDATA_O <= {24'h00_0000, rd_d};
      end
   end

   // Step tick divider, runs only while powered
   // Divider restarts from zero at each power-on
   // so the first step after power-on is full length
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tick_cnt_q <= 16'h0000;
      end else if (!power_on_bit || tick) begin
         tick_cnt_q <= 16'h0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
   end

   // Measurement sequencer: integrate, then optional wait
   // Dropping the run gate returns to idle at once
   // Integration takes step plus one ticks
   // Wait takes wait length plus one ticks
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_q        <= ST_IDLE;
         step_cnt_q     <= 16'h0000;
         INTEG_ACTIVE_O <= 1'b0;
         MEAS_DONE_O    <= 1'b0;
      end else begin
         MEAS_DONE_O <= 1'b0;
         if (!MEAS_RUN_O) begin
            state_q        <= ST_IDLE;
            step_cnt_q     <= 16'h0000;
            INTEG_ACTIVE_O <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  state_q        <= ST_INTEG;
                  step_cnt_q     <= 16'h0000;
                  INTEG_ACTIVE_O <= 1'b1;
               end
               ST_INTEG: begin
                  if (tick) begin
                     if (step_cnt_q == INTEG_STEP_O) begin
                        MEAS_DONE_O <= 1'b1;
                        step_cnt_q  <= 16'h0000;
                        if (pwr_q[`SSEN_PWR_WAIT]) begin
                           state_q        <= ST_WAIT;
                           INTEG_ACTIVE_O <= 1'b0;
                        end
                     end else begin
                        step_cnt_q <= step_cnt_q + 16'h0001;
                     end
                  end
               end
               ST_WAIT: begin
                  if (tick) begin
                     if (step_cnt_q[7:0] == wait_len_q) begin
                        state_q        <= ST_INTEG;
                        step_cnt_q     <= 16'h0000;
                        INTEG_ACTIVE_O <= 1'b1;
                     end else begin
                        step_cnt_q <= step_cnt_q + 16'h0001;
                     end
                  end
               end
               default: begin
                  state_q        <= ST_IDLE;
                  INTEG_ACTIVE_O <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // ssen_regs

// *** testbench/ssen_regs_asserts.sv ***
`timescale 1ns/1ps
module ssen_chk #(
   parameter RUN_WHEN_ONE = 1
) (
   input wire        CLK_SYS_I,
   input wire        RSTN_I,
   input wire [9:0]  AVS_ADDRESS_I,
   input wire        AVS_READ_I,
   input wire        AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0]  AVS_BYTEENABLE_I,
   input wire        AVS_WAITREQUEST_O,
   input wire        OSC_EN_O,
   input wire        MEAS_RUN_O,
   input wire        FLICKER_EN_O,
   input wire        MUX_START_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   // Accepted write to the power register
   wire       pwr_wr = AVS_WRITE_I & ~AVS_WAITREQUEST_O & AVS_BYTEENABLE_I[0]
                       & (AVS_ADDRESS_I == 10'h200);
   wire [7:0] wd = AVS_WRITEDATA_I[7:0];
   wire       launch_d = pwr_wr & wd[4];
   reg  [1:0] launch_q;
   // Recent launch writes, a pulse may only follow one
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) launch_q <= 2'b00;
      else launch_q <= {launch_q[0], launch_d};
   end
   sequence pwr_wr_s;
      pwr_wr;
   endsequence
   osc_follow_a: assert property (pwr_wr_s |=> OSC_EN_O == $past(wd[0]))
      else $error("oscillator enable does not follow write");
   flick_follow_a: assert property (pwr_wr_s |=> FLICKER_EN_O == ($past(wd[6]) & $past(wd[0])))
      else $error("flicker enable does not follow write");
   run_follow_a: assert property (pwr_wr_s |=> MEAS_RUN_O ==
      ($past(wd[0]) & ($past(wd[1]) == (RUN_WHEN_ONE != 0))))
      else $error("measurement gate does not follow write");
   osc_gate_a: assert property (!OSC_EN_O |-> !MEAS_RUN_O && !FLICKER_EN_O)
      else $error("function active while powered down");
   pwr_hold_a: assert property (!pwr_wr |=> $stable(OSC_EN_O) && $stable(FLICKER_EN_O))
      else $error("enables changed without a write");
   mux_cause_a: assert property (MUX_START_O |-> |launch_q)
      else $error("mux start without launch write");
   mux_single_a: assert property (MUX_START_O |=> !MUX_START_O)
      else $error("mux start longer than one cycle");
   wait_one_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
      |=> !AVS_WAITREQUEST_O)
      else $error("more than one wait cycle");
endmodule // ssen_chk

bind ssen_regs ssen_chk #(.RUN_WHEN_ONE(RUN_WHEN_ONE)) i_chk (
   .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .OSC_EN_O(OSC_EN_O),
   .MEAS_RUN_O(MEAS_RUN_O), .FLICKER_EN_O(FLICKER_EN_O), .MUX_START_O(MUX_START_O));

// *** testbench/ssen_host.sv ***
`timescale 1ns/1ps
module ssen_host (
   input  wire        clk_i,
   output reg  [9:0]  adr_o = 10'h000,
   output reg         rd_o = 1'b0,
   output reg         wr_o = 1'b0,
   output reg  [31:0] wd_o = 32'h00000000,
   output reg  [3:0]  be_o = 4'h1,
   input  wire        wait_i,
   input  wire [31:0] rdata_i
);
   // One bus cycle, held until waitrequest is seen low at a rising edge
   task xfer(input bit w, input [7:0] idx, input [7:0] d, output [31:0] q);
      begin
         adr_o <= {idx, 2'b00};
         wd_o <= {24'h000000, d};
         wr_o <= w;
         rd_o <= !w;
         @(posedge clk_i);
         while (wait_i !== 1'b0) @(posedge clk_i);
         q = rdata_i;
         wr_o <= 1'b0;
         rd_o <= 1'b0;
         adr_o <= ~adr_o; // Released lines show no stale value
         wd_o <= ~wd_o;
         @(posedge clk_i);
      end
   endtask
   // Power on, then enables, then the run bits
   task start_run(input [7:0] ien, input [7:0] src, input [7:0] pwr);
      logic [31:0] q;
      begin
         xfer(1'b1, 8'h80, 8'h01, q);
         xfer(1'b1, 8'hf9, ien, q);
         xfer(1'b1, 8'hb2, src, q);
         xfer(1'b1, 8'h80, pwr, q);
      end
   endtask
endmodule // ssen_host

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`include "ssen_defs.vh"
module testbench;
   logic        clk, rd, wr, wt, osc, run, fen, mdone, irq, integ, pop, mstart;
   logic [2:0]  act;
   logic [7:0]  pctl, wl;
   int          act_n = 0;
   int          pop_n = 0;
   int          mst_n = 0;
   logic        rst_n = 1'b0;
   logic        mux_done = 1'b0;
   logic        pin_in = 1'b0;
   logic [7:0]  flick = 8'h00;
   logic [7:0]  lvl = 8'h00;
   logic [15:0] bdat = 16'h0000;
   logic [9:0]  adr;
   logic [31:0] wd, rdat, q;
   logic [3:0]  be, fgc, sgc;
   logic [15:0] step;
   logic [7:0]  vals [6];
   logic [7:0]  rw_tab [6] = '{8'hca, 8'hcb, 8'hcf, 8'hd6, 8'hd8, 8'hda};
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          p;
   ssen_regs i_dut (
      .CLK_SYS_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
      .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt), .MUX_DONE_I(mux_done),
      .FLICKER_STATUS_I(flick), .PIN_IN_I(pin_in), .BUF_LEVEL_I(lvl),
      .BUF_DATA_I(bdat), .OSC_EN_O(osc), .MEAS_RUN_O(run), .FLICKER_EN_O(fen),
      .MUX_START_O(mstart), .INTEG_ACTIVE_O(integ), .MEAS_DONE_O(mdone), .BUF_POP_O(pop),
      .ACTION_O(act), .INTEG_STEP_O(step), .FLICKER_GAIN_CEIL_O(fgc),
      .SPECTRAL_GAIN_CEIL_O(sgc), .PIN_CTL_O(pctl), .IRQ_O(irq));
   ssen_host i_host (.clk_i(clk), .adr_o(adr), .rd_o(rd), .wr_o(wr), .wd_o(wd),
      .be_o(be), .wait_i(wt), .rdata_i(rdat));
   // Clock and hang limit
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   // Count one-cycle strobes as the design shows them
   always @(posedge clk) begin
      if (act == 3'b111) act_n <= act_n + 1;
      if (pop === 1'b1) pop_n <= pop_n + 1;
      if (mstart === 1'b1) mst_n <= mst_n + 1;
   end
   // Expected cycles between two measurement-done pulses
   function automatic int exp_period(input [15:0] st, input [7:0] wlen, input bit wen);
      return (st + 1 + (wen ? wlen + 1 : 0)) * `SSEN_STEP_CYC;
   endfunction
   task chk(input string nm, input [31:0] e, input [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wrr(input [7:0] i, input [7:0] v);
      i_host.xfer(1'b1, i, v, q);
   endtask
   task rdc(input [7:0] i, input [7:0] e);
      i_host.xfer(1'b0, i, 8'h00, q);
      chk($sformatf("reg %h", i), {24'h000000, e}, q);
   endtask
   task mux_pulse;
      mux_done <= 1'b1;
      @(posedge clk);
      mux_done <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // Cycles between two measurement-done pulses
   task period(output int n);
      n = 1;
      while (mdone !== 1'b1) @(posedge clk);
      @(posedge clk);
      while (mdone !== 1'b1) begin
         @(posedge clk);
         n++;
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(28987));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(8'h80, 8'h00);
      rdc(8'hbe, 8'h02);
      $display("test reset done");
      foreach (rw_tab[k]) begin
         vals[k] = 8'($urandom);
         wrr(rw_tab[k], vals[k]);
         rdc(rw_tab[k], vals[k]);
      end
      chk("step", {vals[1], vals[0]}, step);
      chk("gain", vals[2], {fgc, sgc});
      $display("test config done");
      wrr(8'h80, 8'h01);
      wrr(8'h80, 8'hff);
      rdc(8'h80, 8'h5b);
      chk("mux start", 1, mst_n);
      chk("enables", 3'b111, {osc, run, fen});
      mux_pulse();
      rdc(8'h80, 8'h4b);
      wrr(8'h80, 8'h00);
      chk("enables", 3'b000, {osc, run, fen});
      $display("test power done");
      lvl <= 8'($urandom);
      bdat <= 16'($urandom);
      @(posedge clk);
      wrr(8'hfd, ~lvl);
      rdc(8'hfd, lvl);
      rdc(8'hff, bdat[15:8]);
      rdc(8'hfe, bdat[7:0]);
      chk("pop", 1, pop_n);
      wrr(8'hfa, 8'h07);
      rdc(8'hfa, 8'h00);
      chk("action", 1, act_n);
      wrr(8'hdb, 8'hff);
      rdc(8'hdb, flick);
      wrr(8'hbe, 8'hff);
      pin_in <= 1'b1;
      chk("pin ctl", 8'h0e, pctl);
      rdc(8'hbe, 8'h0f);
      rdc(8'h10, 8'h00);
      $display("test readonly done");
      i_host.start_run(8'h01, 8'h50, 8'h01);
      wrr(8'he1, 8'h03);
      wrr(8'he0, 8'h0f);
      chk("irq", 0, irq);
      wrr(8'h80, 8'h11);
      wrr(8'h80, 8'h11);
      mux_pulse();
      chk("irq", 1, irq);
      rdc(8'he0, 8'h01);
      chk("mux start", 2, mst_n);
      wrr(8'he1, 8'h00);
      chk("irq", 0, irq);
      wrr(8'he0, 8'h01);
      wrr(8'he1, 8'h03);
      chk("irq", 0, irq);
      flick <= ~flick;
      repeat (3) @(posedge clk);
      chk("irq", 1, irq);
      wrr(8'hf9, 8'h00);
      chk("irq", 0, irq);
      $display("test interrupt done");
      wrr(8'he0, 8'h0f);
      wrr(8'hca, 8'h00);
      wrr(8'hcb, 8'h00);
      wl = 8'($urandom % 4);
      wrr(8'he2, wl);
      wrr(8'h80, 8'h03);
      period(p);
      period(p);
      chk("period", exp_period(16'h0000, wl, 1'b0), p);
      chk("integ", 1, integ);
      wrr(8'h80, 8'h0b);
      period(p);
      period(p);
      chk("period", exp_period(16'h0000, wl, 1'b1), p);
      chk("integ", 0, integ);
      wrr(8'hcf, 8'h5a);
      i_host.xfer(1'b0, 8'he0, 8'h00, q);
      chk("cfg flag", 32'h4, q & 32'h4);
      $display("test measure done");
      summarize();
   end
endmodule // testbench
